// ===== rtl/boot_memory_swap_decoder.sv
// Overview of operation
// - With the execution-source bit set, main flash segment zero decodes at 0x0 and boot selects leave the map unless BOOT_ALT_EN moves them to 0x80000.
// - With the bit clear, the boot segments decode from 0x0 and main flash segment zero sits high.
// - Main flash segment zero decodes two ranges, one qualified by the bit set and one by it clear; the boot segments do so only with BOOT_ALT_EN set.
// - The execution-source bit is bit six of the segment select register feeding the decode.
// - The host reads and writes the segment select register over its bus.
// - The segment select register resets to zero so execution starts from boot flash.
// - The new map applies from the cycle after the register write completes.
// - Code memory, SRAM, display and register space are decoded on the 16-bit multiplexed bus.
// - During programming the device leaves the host bus and holds the host in reset.
// - The programming port is enabled from reset with no prior configuration.
`timescale 1ns/1ns
`default_nettype none
module boot_memory_swap_decoder #(
  parameter bit BOOT_ALT_EN = 1'b0
) (
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          rstn_in,
  // Host multiplexed bus
  input  wire logic                          ale_in,
  input  wire logic                          rd_n_in,
  input  wire logic                          wr_n_in,
  input  wire logic                          psen_n_in,
  input  wire logic [swap_pkg::HI_W-1:0]     addr_hi_in,
  input  wire logic [swap_pkg::DATA_W-1:0]   ad_in,
  output logic      [swap_pkg::DATA_W-1:0]   ad_out,
  output logic                               ad_oe_out,
  // Memory and peripheral selects
  output logic                               boot_flash_select_zero_out,
  output logic                               boot_flash_select_one_out,
  output logic                               main_flash_select_zero_out,
  output logic                               sram_select_out,
  output logic                               display_select_out,
  output logic                               device_register_space_out,
  output logic                               exe_src_out,
  // Programming port
  input  wire logic                          isp_request_in,
  output logic                               jtag_port_enable_out,
  output logic                               isp_active_out,
  output logic                               host_reset_out,
  output logic                               host_reset_oe_out
);
  import swap_pkg::*;

  localparam int PIN_W = 5 + HI_W + DATA_W;

  pin_sample_if #(.W(PIN_W)) pins ();

  // Active-high pins pass inverted so the filter's all-ones reset level reads as idle
  assign pins.raw = {~ale_in, rd_n_in, wr_n_in, psen_n_in, ~isp_request_in, addr_hi_in, ad_in};

  pin_sampler #(.W(PIN_W)) u_sampler (
    .clk_in  (ref_clk_in),
    .rstn_in (rstn_in),
    .port    (pins)
  );

  // Filtered pin levels
  wire              ale_c    = ~pins.clean[PIN_W-1];
  wire              rd_n_c   = pins.clean[PIN_W-2];
  wire              wr_n_c   = pins.clean[PIN_W-3];
  wire              psen_n_c = pins.clean[PIN_W-4];
  wire              isp_c    = ~pins.clean[PIN_W-5];
  wire [HI_W-1:0]   hi_c     = pins.clean[DATA_W +: HI_W];
  wire [DATA_W-1:0] ad_c     = pins.clean[DATA_W-1:0];

  bus_state_type     state_q;
  bus_state_type     state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [REG_W-1:0]  wdata_q;
  logic              wr_n_prev_q;
  logic [REG_W-1:0]  page_q;
  logic [REG_W-1:0]  vis_q;
  logic [REG_W-1:0]  isp_ctrl_q;
  logic [DATA_W-1:0] ad_q;
  logic              ad_oe_q;
  logic              boot0_q;
  logic              boot1_q;
  logic              fs0_q;
  logic              sram_q;
  logic              disp_q;
  logic              regs_q;
  logic              host_oe_q;
  logic              swap_pend_q;
  logic              swap_bit_q;

  // Programming only takes the bus while the port is enabled
  wire isp_active = isp_c & isp_ctrl_q[ISP_EN_BIT];

  wire exe = page_q[EXE_SRC_BIT];

  // Address decode
  wire [OFS_W-1:0] ofs      = addr_q[OFS_W-1:0];
  wire             reg_hit  = in_range(addr_q, REGS_LO, REGS_HI);
  wire             sram_hit = in_range(addr_q, SRAM_LO, SRAM_HI);
  wire             disp_hit = in_range(addr_q, DISP_LO, DISP_HI);
  wire             b0_hit   = (in_range(addr_q, BOOT0_LO, BOOT0_HI) & ~exe)
                            | (BOOT_ALT_EN & in_range(addr_q, BOOT0_ALT_LO, BOOT0_ALT_HI)
                               & exe);
  wire             b1_hit   = (in_range(addr_q, BOOT1_LO, BOOT1_HI) & ~exe)
                            | (BOOT_ALT_EN & in_range(addr_q, BOOT1_ALT_LO, BOOT1_ALT_HI)
                               & exe);
  wire             fs0_hit  = (in_range(addr_q, FS0_ALT_LO, FS0_ALT_HI) & ~exe)
                            | (in_range(addr_q, FS0_EXEC_LO, FS0_EXEC_HI) & exe);

  // Cycle kinds
  wire fetch_cyc = (state_q == PH_FETCH);
  wire read_cyc  = (state_q == PH_READ);
  wire write_cyc = (state_q == PH_WRITE);
  wire data_cyc  = read_cyc | write_cyc;
  wire live      = ~isp_active;

  // Flash seen in data space only where the visibility register allows it
  wire boot_ok = fetch_cyc | (data_cyc & vis_q[VIS_BOOT_BIT]);
  wire main_ok = fetch_cyc | (data_cyc & vis_q[VIS_MAIN_BIT]);

  wire boot0_d = live & b0_hit & boot_ok;
  wire boot1_d = live & b1_hit & boot_ok;
  wire fs0_d   = live & fs0_hit & main_ok;
  wire sram_d  = live & data_cyc & sram_hit;
  wire disp_d  = live & data_cyc & disp_hit;
  wire regs_d  = live & data_cyc & reg_hit;

  // Register write lands when the write strobe rises
  wire wr_done  = write_cyc & ~wr_n_prev_q & wr_n_c & live;
  wire page_wr  = wr_done & reg_hit & (ofs == OFS_PAGE);
  wire vis_wr   = wr_done & reg_hit & (ofs == OFS_VIS);
  wire isp_wr   = wr_done & reg_hit & (ofs == OFS_ISP);

  wire [REG_W-1:0] rd_mux = (ofs == OFS_PAGE) ? page_q :
                            (ofs == OFS_VIS)  ? vis_q  :
                            (ofs == OFS_ISP)  ? isp_ctrl_q : '0;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PH_IDLE: begin
        if (ale_c) begin
          state_d = PH_ADDR;
        end
      end
      PH_ADDR: begin
        if (!ale_c && !psen_n_c) begin
          state_d = PH_FETCH;
        end else if (!ale_c && !rd_n_c) begin
          state_d = PH_READ;
        end else if (!ale_c && !wr_n_c) begin
          state_d = PH_WRITE;
        end
      end
      PH_FETCH: begin
        if (psen_n_c) begin
          state_d = PH_IDLE;
        end
      end
      PH_READ: begin
        if (rd_n_c) begin
          state_d = PH_IDLE;
        end
      end
      PH_WRITE: begin
        if (wr_n_c) begin
          state_d = PH_IDLE;
        end
      end
      default: begin
        state_d = PH_IDLE;
      end
    endcase
    if (isp_active) begin
      state_d = PH_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state_q     <= PH_IDLE;
      addr_q      <= '0;
      wdata_q     <= '0;
      wr_n_prev_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      wr_n_prev_q <= wr_n_c;
      if (ale_c) begin
        addr_q <= {hi_c, ad_c};
      end
      if (!wr_n_c) begin
        wdata_q <= ad_c[REG_W-1:0];
      end
    end
  end

  // Software registers; visible the cycle after the write so the next fetch sees the new map
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      page_q     <= PAGE_RESET;
      vis_q      <= VIS_RESET;
      isp_ctrl_q  <= ISP_RESET;
      swap_pend_q <= 1'b0;
      swap_bit_q  <= 1'b0;
    end else begin
      // Marks the first fetch after a segment select write for the remap check
      swap_pend_q <= page_wr | (swap_pend_q & ~fetch_cyc);
      if (page_wr) begin
        page_q     <= wdata_q;
        swap_bit_q <= wdata_q[EXE_SRC_BIT];
      end
      if (vis_wr) begin
        vis_q <= wdata_q;
      end
      if (isp_wr) begin
        isp_ctrl_q <= wdata_q;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      boot0_q   <= 1'b0;
      boot1_q   <= 1'b0;
      fs0_q     <= 1'b0;
      sram_q    <= 1'b0;
      disp_q    <= 1'b0;
      regs_q    <= 1'b0;
      ad_q      <= '0;
      ad_oe_q   <= 1'b0;
      host_oe_q <= 1'b0;
    end else begin
      boot0_q   <= boot0_d;
      boot1_q   <= boot1_d;
      fs0_q     <= fs0_d;
      sram_q    <= sram_d;
      disp_q    <= disp_d;
      regs_q    <= regs_d;
      ad_q      <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
      ad_oe_q   <= live & read_cyc & reg_hit;
      host_oe_q <= isp_active;
    end
  end

  assign ad_out                     = ad_q;
  assign ad_oe_out                  = ad_oe_q;
  assign boot_flash_select_zero_out = boot0_q;
  assign boot_flash_select_one_out  = boot1_q;
  assign main_flash_select_zero_out = fs0_q;
  assign sram_select_out            = sram_q;
  assign display_select_out         = disp_q;
  assign device_register_space_out  = regs_q;
  assign exe_src_out                = exe;
  assign jtag_port_enable_out       = isp_ctrl_q[ISP_EN_BIT];
  assign isp_active_out             = host_oe_q;
  // Open-drain reset: only ever pulls low, the board pull-up releases it
  assign host_reset_out             = 1'b0;
  assign host_reset_oe_out          = host_oe_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  wire fetch_exec = fetch_cyc & live & in_range(addr_q, FS0_EXEC_LO, FS0_EXEC_HI);
  wire fetch_b0   = fetch_cyc & live & in_range(addr_q, BOOT0_LO, BOOT0_HI);
  wire fetch_alt  = fetch_cyc & live & in_range(addr_q, FS0_ALT_LO, FS0_ALT_HI);

  a_exec_main_map: assert property (
    exe && fetch_exec |=> main_flash_select_zero_out && !boot_flash_select_zero_out
                          && !boot_flash_select_one_out)
    else $error("main flash not at execution region");

  a_exec_boot_map: assert property (
    !exe && fetch_b0 |=> boot_flash_select_zero_out && !main_flash_select_zero_out)
    else $error("boot flash not at execution region");

  a_dual_range: assert property (
    fetch_alt |=> (main_flash_select_zero_out == !$past(exe)))
    else $error("main flash high range not tied to cleared bit");

  a_bit_six_feed: assert property (
    page_wr |=> (exe_src_out == $past(wdata_q[EXE_SRC_BIT])))
    else $error("bit six does not steer decode");

  a_page_readback: assert property (
    read_cyc && live && reg_hit && (ofs == OFS_PAGE)
      |=> ad_oe_out && (ad_out[REG_W-1:0] == page_q))
    else $error("segment select read returns wrong data");

  property p_reset_clear;
    @(posedge ref_clk_in) disable iff (1'b0)
      !rstn_in |=> (page_q == PAGE_RESET) && !exe_src_out && jtag_port_enable_out;
  endproperty
  a_reset_boot: assert property (p_reset_clear)
    else $error("reset does not restore boot map");

  a_remap_next: assert property (
    swap_pend_q && fetch_exec |=> (main_flash_select_zero_out == swap_bit_q))
    else $error("fetch after write not from new segment");

  a_bus_present: assert property (
    read_cyc && live && sram_hit |=> sram_select_out ##1 1'b1)
    else $error("SRAM not selected on data read");

  a_isp_release: assert property (
    isp_active |=> host_reset_oe_out && !ad_oe_out
                   ##1 !(sram_select_out || boot_flash_select_zero_out
                         || main_flash_select_zero_out || device_register_space_out))
    else $error("bus not released during programming");

  a_one_flash: assert property (
    $onehot0({boot_flash_select_zero_out, boot_flash_select_one_out,
              main_flash_select_zero_out}))
    else $error("more than one flash select active");

  c_swap_to_main: cover property (page_wr && wdata_q[EXE_SRC_BIT]);
  c_fetch_main:   cover property (exe && fetch_exec ##1 main_flash_select_zero_out);
  c_reg_read:     cover property (ad_oe_out);
  c_isp_hold:     cover property (host_reset_oe_out [*3]);

endmodule // boot_memory_swap_decoder
`default_nettype wire

// ===== rtl/pin_sample_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pin_sample_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sampler (input raw, output clean);
  modport user    (output raw, input clean);
endinterface
`default_nettype wire

// ===== rtl/pin_sampler.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sampler #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic          clk_in,
  input wire logic          rstn_in,
  // Pins in, filtered levels out
  pin_sample_if.sampler     port
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  // A bit moves only when the last two stages agree, so one noisy sample is ignored
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_q    <= '1;
      s2_q    <= '1;
      s3_q    <= '1;
      clean_q <= '1;
    end else begin
      s1_q    <= port.raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      clean_q <= (agree & s3_q) | (~agree & clean_q);
    end
  end

  assign port.clean = clean_q;
endmodule // pin_sampler
`default_nettype wire

// ===== rtl/swap_pkg.sv
package swap_pkg;

  // Bus widths
  localparam int ADDR_W = 20;
  localparam int HI_W   = 4;
  localparam int DATA_W = 16;
  localparam int REG_W  = 8;
  localparam int OFS_W  = 8;

  // Relocatable segments, both placements
  localparam logic [ADDR_W-1:0] BOOT0_LO     = 20'h00000;
  localparam logic [ADDR_W-1:0] BOOT0_HI     = 20'h01fff;
  localparam logic [ADDR_W-1:0] BOOT1_LO     = 20'h02000;
  localparam logic [ADDR_W-1:0] BOOT1_HI     = 20'h03fff;
  localparam logic [ADDR_W-1:0] BOOT0_ALT_LO = 20'h80000;
  localparam logic [ADDR_W-1:0] BOOT0_ALT_HI = 20'h81fff;
  localparam logic [ADDR_W-1:0] BOOT1_ALT_LO = 20'h82000;
  localparam logic [ADDR_W-1:0] BOOT1_ALT_HI = 20'h83fff;
  localparam logic [ADDR_W-1:0] FS0_EXEC_LO  = 20'h00000;
  localparam logic [ADDR_W-1:0] FS0_EXEC_HI  = 20'h03fff;
  localparam logic [ADDR_W-1:0] FS0_ALT_LO   = 20'h80000;
  localparam logic [ADDR_W-1:0] FS0_ALT_HI   = 20'h8ffff;

  // Fixed resources
  localparam logic [ADDR_W-1:0] SRAM_LO = 20'h04000;
  localparam logic [ADDR_W-1:0] SRAM_HI = 20'h05fff;
  localparam logic [ADDR_W-1:0] DISP_LO = 20'h06000;
  localparam logic [ADDR_W-1:0] DISP_HI = 20'h060ff;
  localparam logic [ADDR_W-1:0] REGS_LO = 20'h07000;
  localparam logic [ADDR_W-1:0] REGS_HI = 20'h070ff;

  // Register offsets inside the device register space
  localparam logic [OFS_W-1:0] OFS_PAGE = 8'he0;
  localparam logic [OFS_W-1:0] OFS_VIS  = 8'he2;
  localparam logic [OFS_W-1:0] OFS_ISP  = 8'he4;

  // Field positions
  localparam int EXE_SRC_BIT   = 6;
  localparam int VIS_BOOT_BIT  = 0;
  localparam int VIS_MAIN_BIT  = 1;
  localparam int ISP_EN_BIT    = 0;

  // Reset values
  localparam logic [REG_W-1:0] PAGE_RESET = 8'h00;
  localparam logic [REG_W-1:0] VIS_RESET  = 8'h00;
  localparam logic [REG_W-1:0] ISP_RESET  = 8'h01;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_ADDR  = 3'b001,
    PH_FETCH = 3'b010,
    PH_READ  = 3'b011,
    PH_WRITE = 3'b100
  } bus_state_type;

  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

// ===== verification/boot_memory_swap_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module boot_memory_swap_decoder_tb;
  import swap_pkg::*;
  localparam logic [5:0] S_B0 = 6'h20, S_B1 = 6'h10, S_M0 = 6'h08;
  localparam logic [5:0] S_RAM = 6'h04, S_DSP = 6'h02, S_REG = 6'h01;
  localparam logic [ADDR_W-1:0] MAP_A [9] = '{BOOT0_LO, BOOT0_HI, BOOT1_LO, BOOT1_HI,
    SRAM_LO, DISP_LO, REGS_LO, FS0_ALT_LO, FS0_ALT_HI};
  localparam logic [5:0] EXP_CLR [9] = '{S_B0, S_B0, S_B1, S_B1, S_RAM, S_DSP, S_REG,
    S_M0, S_M0};
  // With the bit set the boot segments have no second range in this build
  localparam logic [5:0] EXP_SET [9] = '{S_M0, S_M0, S_M0, S_M0, S_RAM, S_DSP, S_REG,
    6'h00, 6'h00};

  logic              ref_clk_in = 1'b0;
  logic              rstn_in = 1'b0;
  logic              isp_request_in = 1'b0;
  wire logic         ale, rd_n, wr_n, psen_n;
  wire logic [3:0]   addr_hi;
  wire logic [15:0]  ad_bus, ad_dev;
  wire logic         ad_oe, b0, b1, m0, ram, dsp, regs, exe_src;
  wire logic         jtag_en, isp_act, hr_val, hr_oe;
  wire logic [5:0]   sel;
  wire logic         host_rst_n;
  int                failures = 0;
  int                compares = 0;

  always #50 ref_clk_in = ~ref_clk_in;
  assign sel = {b0, b1, m0, ram, dsp, regs};
  // Open-drain reset line with a pull-up
  assign host_rst_n = hr_oe ? hr_val : 1'b1;

  boot_memory_swap_decoder #(.BOOT_ALT_EN(1'b0)) dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ale_in(ale), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .psen_n_in(psen_n), .addr_hi_in(addr_hi), .ad_in(ad_bus),
    .ad_out(ad_dev), .ad_oe_out(ad_oe), .boot_flash_select_zero_out(b0),
    .boot_flash_select_one_out(b1), .main_flash_select_zero_out(m0),
    .sram_select_out(ram), .display_select_out(dsp), .device_register_space_out(regs),
    .exe_src_out(exe_src), .isp_request_in(isp_request_in), .jtag_port_enable_out(jtag_en),
    .isp_active_out(isp_act), .host_reset_out(hr_val), .host_reset_oe_out(hr_oe));

  host_bus_model host (
    .clk_in(ref_clk_in), .dev_ad_in(ad_dev), .dev_oe_in(ad_oe), .sel_in(sel),
    .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n), .psen_n_out(psen_n),
    .addr_hi_out(addr_hi), .ad_out(ad_bus));

  task automatic chk_sel(input string what, input logic [5:0] exp, input logic [5:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic fetch_sel(input logic [ADDR_W-1:0] a, output logic [5:0] s);
    logic [15:0] d;
    host.bus_cycle(0, a, 16'h0000, s, d);
  endtask

  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] v);
    logic [5:0]  s;
    logic [15:0] d;
    host.bus_cycle(2, {REGS_LO[19:8], ofs}, {8'h00, v}, s, d);
  endtask

  task automatic reg_rd(input logic [7:0] ofs, output logic [15:0] d);
    logic [5:0] s;
    host.bus_cycle(1, {REGS_LO[19:8], ofs}, 16'h0000, s, d);
  endtask

  task automatic test_reset;
    logic [15:0] d;
    chk_val("exe_src after reset", 16'h0000, {15'h0, exe_src});
    chk_val("port enable after reset", 16'h0001, {15'h0, jtag_en});
    chk_val("host reset pull", 16'h0000, {15'h0, hr_oe});
    chk_sel("selects after reset", 6'h00, sel);
    reg_rd(OFS_PAGE, d);
    chk_val("segment select reset", {8'h00, PAGE_RESET}, d);
    $display("test reset done");
  endtask

  task automatic test_map(input logic set);
    logic [5:0]  s;
    logic [15:0] d;
    for (int i = 0; i < 9; i++) begin
      // SRAM, display and register space answer data cycles, flash answers fetches
      if (i >= 4 && i <= 6) begin
        host.bus_cycle(1, MAP_A[i], 16'h0000, s, d);
      end else begin
        fetch_sel(MAP_A[i], s);
      end
      chk_sel("map select", set ? EXP_SET[i] : EXP_CLR[i], s);
    end
    $display("test map done, bit %0d", set);
  endtask

  task automatic test_swap;
    logic [5:0]  s;
    logic [15:0] d;
    reg_wr(OFS_PAGE, 8'h40);
    chk_val("exe_src after write", 16'h0001, {15'h0, exe_src});
    // First fetch straight after the write must already come from main flash
    fetch_sel(BOOT0_LO, s);
    chk_sel("first fetch after swap", S_M0, s);
    reg_rd(OFS_PAGE, d);
    chk_val("segment select readback", 16'h0040, d);
    test_map(1'b1);
    reg_wr(OFS_PAGE, 8'hbf);
    chk_val("exe_src other bits", 16'h0000, {15'h0, exe_src});
    fetch_sel(BOOT1_LO, s);
    chk_sel("fetch after swap back", S_B1, s);
    reg_rd(OFS_PAGE, d);
    chk_val("segment select readback", 16'h00bf, d);
    reg_wr(OFS_PAGE, 8'h00);
    $display("test swap done");
  endtask

  task automatic test_visibility;
    logic [5:0]  s;
    logic [15:0] d;
    host.set_map(8'h00, 8'h03);
    host.bus_cycle(1, FS0_ALT_LO, 16'h0000, s, d);
    chk_sel("data read main flash visible", S_M0, s);
    host.bus_cycle(1, BOOT0_LO, 16'h0000, s, d);
    chk_sel("data read boot flash visible", S_B0, s);
    host.set_map(8'h00, 8'h00);
    host.bus_cycle(1, FS0_ALT_LO, 16'h0000, s, d);
    chk_sel("data read main flash hidden", 6'h00, s);
    host.bus_cycle(1, BOOT1_LO, 16'h0000, s, d);
    chk_sel("data read boot flash hidden", 6'h00, s);
    reg_rd(8'hf0, d);
    chk_val("unmapped register read", 16'h0000, d);
    $display("test visibility done");
  endtask

  task automatic test_isp;
    logic [5:0] s;
    isp_request_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk_val("host held in reset", 16'h0002, {14'h0, isp_act, host_rst_n});
    fetch_sel(BOOT0_LO, s);
    chk_sel("bus detached during programming", 6'h00, s);
    reg_wr(OFS_PAGE, 8'h40);
    chk_val("write ignored during programming", 16'h0000, {15'h0, exe_src});
    isp_request_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk_val("host released", 16'h0001, {14'h0, isp_act, host_rst_n});
    reg_wr(OFS_ISP, 8'h00);
    chk_val("port disabled", 16'h0000, {15'h0, jtag_en});
    isp_request_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    fetch_sel(BOOT0_LO, s);
    chk_sel("request blocked when disabled", S_B0, s);
    chk_val("no reset when disabled", 16'h0001, {15'h0, host_rst_n});
    isp_request_in = 1'b0;
    reg_wr(OFS_ISP, 8'h01);
    chk_val("port enabled again", 16'h0001, {15'h0, jtag_en});
    $display("test programming done");
  endtask

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hung sequence counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    $display("CHECK FAILED run length expected below 20000 cycles seen limit");
    tally_and_finish();
  end

  initial begin
    repeat (16) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    @(negedge ref_clk_in);
    test_reset();
    test_map(1'b0);
    test_swap();
    test_visibility();
    test_isp();
    tally_and_finish();
  end
endmodule // boot_memory_swap_decoder_tb
`default_nettype wire

// ===== verification/host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import swap_pkg::*;
(
  // Clock
  input  wire logic                        clk_in,
  // Device answer
  input  wire logic [swap_pkg::DATA_W-1:0] dev_ad_in,
  input  wire logic                        dev_oe_in,
  input  wire logic [5:0]                  sel_in,
  // Bus pins toward the device
  output logic                             ale_out,
  output logic                             rd_n_out,
  output logic                             wr_n_out,
  output logic                             psen_n_out,
  output logic [swap_pkg::HI_W-1:0]        addr_hi_out,
  output logic [swap_pkg::DATA_W-1:0]      ad_out
);
  // Each level is held well past the four-flop filter of the device
  localparam int HOLD = 6;
  logic [DATA_W-1:0] host_val;
  logic              host_drv;

  // A released bus shows the inverse of the last value, so stale data never reads as valid
  assign ad_out = dev_oe_in ? dev_ad_in : (host_drv ? host_val : ~host_val);

  initial begin
    ale_out     = 1'b0;
    rd_n_out    = 1'b1;
    wr_n_out    = 1'b1;
    psen_n_out  = 1'b1;
    addr_hi_out = 4'h0;
    host_val    = 16'h0000;
    host_drv    = 1'b0;
  end

  // Kind 0 fetch, 1 data read, 2 data write; called just after a falling edge
  task automatic bus_cycle(input int kind, input logic [ADDR_W-1:0] addr,
                           input logic [DATA_W-1:0] wdata,
                           output logic [5:0] sel, output logic [DATA_W-1:0] rdata);
    ale_out     = 1'b1;
    addr_hi_out = addr[19:16];
    host_val    = addr[15:0];
    host_drv    = 1'b1;
    repeat (HOLD) @(negedge clk_in);
    ale_out  = 1'b0;
    host_val = wdata;
    host_drv = (kind == 2);
    if (kind == 0) begin
      psen_n_out = 1'b0;
    end else if (kind == 1) begin
      rd_n_out = 1'b0;
    end else begin
      wr_n_out = 1'b0;
    end
    repeat (HOLD) @(negedge clk_in);
    sel        = sel_in;
    rdata      = ad_out;
    psen_n_out = 1'b1;
    rd_n_out   = 1'b1;
    wr_n_out   = 1'b1;
    // Write data stays on the bus until the strobe release has passed the filter
    repeat (HOLD) @(negedge clk_in);
    host_drv = 1'b0;
    // One idle cycle so the next call never re-drives the bus in the same step
    @(negedge clk_in);
  endtask

  // Startup map set-up: segment select first, then visibility
  task automatic set_map(input logic [7:0] page, input logic [7:0] vis);
    logic [5:0]        s;
    logic [DATA_W-1:0] d;
    bus_cycle(2, {REGS_LO[19:8], OFS_PAGE}, {8'h00, page}, s, d);
    bus_cycle(2, {REGS_LO[19:8], OFS_VIS}, {8'h00, vis}, s, d);
  endtask
endmodule // host_bus_model
`default_nettype wire
